// ===== cps_pkg.sv
/*
 * Constants, field values and state codes of the control port.
 * Assumes a single core clock and a register file of byte-wide registers.
 */
// What this block does
// - i2c and spi modes, both read and write
// - byte registers at 0x00 through 0x1a
// - slave only, never starts a transfer
// - access works without the master clock
// - reset to i2c; three latch lows enter spi
// - control pins change function with mode
// - address is straps then 10001
// - first byte bit 0 selects read
// - idle watches for start and own address
// - sda falling while scl high is start
// - address and direction shifted msb first
// - matching address acked on ninth clock
// - mismatch releases bus, back to idle
// - sda rising while scl high ends transfer
// - stray stop returns to idle; stray start restarts address reception
// - every written byte acked on ninth clock
// - register address advances after each byte
package cps_pkg;
    localparam logic [7:0] REG_ADDR_FIRST = 8'h00;
    localparam logic [7:0] REG_ADDR_LAST = 8'h1a;
    localparam int REG_COUNT = int'(REG_ADDR_LAST) - int'(REG_ADDR_FIRST) + 1;
    localparam logic [7:0] REG_RESET_VALUE = 8'h00;
    localparam logic [4:0] DEV_ADDR_LOW = 5'h11;
    localparam logic [1:0] SPI_ENTRY_FALLS = 2'h3;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [2:0] LINK_LAST_BIT = 3'h7;
    localparam logic [1:0] BYTE_DEV = 2'h0;
    localparam logic [1:0] BYTE_REG = 2'h1;
    localparam logic [1:0] BYTE_DATA = 2'h2;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_RX = 5'h02,
        ST_ACK = 5'h04,
        ST_TX = 5'h08,
        ST_MACK = 5'h10
    } cps_state_type;
endpackage

// ===== cps_control_port.sv
/*
 * Control port of the converter: i2c slave and spi slave in front of the
 * register file, which this module holds.
 * Assumes the address straps are static and the spi clock pauses between
 * bytes of a read long enough for the core to fetch the next byte.
 */
`timescale 1ns/100ps
module cps_control_port (
    // core clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // pin: i2c data, or spi serial out in spi mode
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // pin: i2c clock, or spi serial clock in spi mode
    input wire logic scl_spi_serial_clock,
    // pins: address straps, or spi latch and serial in
    input wire logic addr_strap_lo_spi_chip_select_latch_n,
    input wire logic addr_strap_hi_spi_serial_in,
    // register file side
    output logic spi_mode,
    output logic reg_wr_stb,
    output logic [7:0] reg_wr_addr,
    output logic [7:0] reg_wr_data,
    output logic [8*cps_pkg::REG_COUNT-1:0] reg_image
);
    // ------------------------------------------------------------
    // link domain: spi shifter on the serial clock
    // ------------------------------------------------------------
    logic lk_frame_rst_n;
    logic [2:0] lk_bit_cnt_q, lk_bit_cnt_d;
    logic [6:0] lk_shift_q, lk_shift_d;
    logic [7:0] lk_byte_q, lk_byte_d;
    logic lk_tgl_q, lk_tgl_d;
    logic ser_out_q;
    logic [7:0] tx_q, tx_d;

    // latch high ends the frame without needing a clock edge
    assign lk_frame_rst_n = rst_n && !addr_strap_lo_spi_chip_select_latch_n;

    always_comb begin
        lk_bit_cnt_d = lk_bit_cnt_q + 3'h1;
        lk_shift_d = {lk_shift_q[5:0], addr_strap_hi_spi_serial_in};
        lk_byte_d = lk_byte_q;
        lk_tgl_d = lk_tgl_q;
        if (lk_bit_cnt_q == cps_pkg::LINK_LAST_BIT) begin
            lk_byte_d = {lk_shift_q, addr_strap_hi_spi_serial_in};
            lk_tgl_d = !lk_tgl_q;
        end
    end

    always_ff @(posedge scl_spi_serial_clock or negedge lk_frame_rst_n) begin
        if (!lk_frame_rst_n) begin
            lk_bit_cnt_q <= 3'h0;
            lk_shift_q <= 7'h00;
        end else begin
            lk_bit_cnt_q <= lk_bit_cnt_d;
            lk_shift_q <= lk_shift_d;
        end
    end

    always_ff @(posedge scl_spi_serial_clock or negedge rst_n) begin
        if (!rst_n) begin
            lk_byte_q <= 8'h00;
            lk_tgl_q <= 1'b0;
        end else begin
            lk_byte_q <= lk_byte_d;
            lk_tgl_q <= lk_tgl_d;
        end
    end

    // serial out changes on the falling edge; tx_q is quiet while a byte shifts
    always_ff @(negedge scl_spi_serial_clock or negedge rst_n) begin
        if (!rst_n) begin
            ser_out_q <= 1'b0;
        end else begin
            ser_out_q <= tx_q[cps_pkg::LINK_LAST_BIT - lk_bit_cnt_q];
        end
    end

    // ------------------------------------------------------------
    // synchronisers into the core domain
    // ------------------------------------------------------------
    logic [1:0] scl_sync_q, sda_sync_q, lo_sync_q, hi_sync_q, tgl_sync_q;
    logic scl_prev_q, sda_prev_q, lo_prev_q, tgl_prev_q;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_sync_q <= 2'h3;
            sda_sync_q <= 2'h3;
            lo_sync_q <= 2'h0;
            hi_sync_q <= 2'h0;
            tgl_sync_q <= 2'h0;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
            lo_prev_q <= 1'b0;
            tgl_prev_q <= 1'b0;
        end else begin
            scl_sync_q <= {scl_sync_q[0], scl_spi_serial_clock};
            sda_sync_q <= {sda_sync_q[0], sda_in};
            lo_sync_q <= {lo_sync_q[0], addr_strap_lo_spi_chip_select_latch_n};
            hi_sync_q <= {hi_sync_q[0], addr_strap_hi_spi_serial_in};
            tgl_sync_q <= {tgl_sync_q[0], lk_tgl_q};
            scl_prev_q <= scl_sync_q[1];
            sda_prev_q <= sda_sync_q[1];
            lo_prev_q <= lo_sync_q[1];
            tgl_prev_q <= tgl_sync_q[1];
        end
    end

    logic scl_rise, scl_fall, start_ev, stop_ev, latch_fall, latch_rise, spi_byte_ev;
    logic [6:0] dev_addr;

    assign scl_rise = scl_sync_q[1] && !scl_prev_q;
    assign scl_fall = !scl_sync_q[1] && scl_prev_q;
    assign start_ev = !spi_mode && scl_sync_q[1] && scl_prev_q && !sda_sync_q[1] && sda_prev_q;
    assign stop_ev = !spi_mode && scl_sync_q[1] && scl_prev_q && sda_sync_q[1] && !sda_prev_q;
    assign latch_fall = !lo_sync_q[1] && lo_prev_q;
    assign latch_rise = lo_sync_q[1] && !lo_prev_q;
    assign spi_byte_ev = tgl_sync_q[1] ^ tgl_prev_q;
    assign dev_addr = {hi_sync_q[1], lo_sync_q[1], cps_pkg::DEV_ADDR_LOW};

    // ------------------------------------------------------------
    // register file and transfer engine
    // ------------------------------------------------------------
    logic [7:0] regs_q [0:cps_pkg::REG_COUNT-1];
    logic [7:0] regs_d [0:cps_pkg::REG_COUNT-1];
    cps_pkg::cps_state_type state_q, state_d;
    logic [3:0] bit_cnt_q, bit_cnt_d;
    logic [7:0] shift_q, shift_d, ptr_q, ptr_d, rd_now;
    logic [1:0] byte_idx_q, byte_idx_d, entry_cnt_q, entry_cnt_d;
    logic rw_q, rw_d, sda_oe_q, sda_oe_d, acked_q, acked_d;
    logic spi_live_q, spi_live_d, ser_out_en_q, ser_out_en_d;
    logic we, data_byte_ev;
    logic [7:0] wa, wd;
    logic wr_stb_q;
    logic [7:0] wr_addr_q, wr_data_q;

    // addresses past the last register read as zero and drop writes
    function automatic logic [7:0] reg_read(input logic [7:0] a);
        if (a <= cps_pkg::REG_ADDR_LAST) begin
            reg_read = regs_q[5'(a - cps_pkg::REG_ADDR_FIRST)];
        end else begin
            reg_read = 8'h00;
        end
    endfunction

    assign spi_mode = (entry_cnt_q == cps_pkg::SPI_ENTRY_FALLS);

    always_comb begin
        state_d = state_q;
        bit_cnt_d = bit_cnt_q;
        shift_d = shift_q;
        ptr_d = ptr_q;
        byte_idx_d = byte_idx_q;
        entry_cnt_d = entry_cnt_q;
        rw_d = rw_q;
        sda_oe_d = sda_oe_q;
        acked_d = acked_q;
        spi_live_d = spi_live_q;
        ser_out_en_d = ser_out_en_q;
        tx_d = tx_q;
        we = 1'b0;
        wa = ptr_q;
        wd = shift_q;
        data_byte_ev = 1'b0;
        rd_now = reg_read(ptr_q);
        if (latch_fall && !spi_mode) begin
            entry_cnt_d = entry_cnt_q + 2'h1;
        end
        if (spi_mode) begin
            // pins now carry the spi functions; the i2c engine is parked
            state_d = cps_pkg::ST_IDLE;
            sda_oe_d = 1'b0;
            if (latch_fall) begin
                spi_live_d = 1'b1;
                byte_idx_d = cps_pkg::BYTE_DEV;
                ser_out_en_d = 1'b0;
            end else if (latch_rise) begin
                spi_live_d = 1'b0;
                ser_out_en_d = 1'b0;
            end else if (spi_byte_ev && spi_live_q) begin
                case (byte_idx_q)
                    cps_pkg::BYTE_DEV: begin
                        rw_d = lk_byte_q[0];
                        byte_idx_d = cps_pkg::BYTE_REG;
                    end
                    cps_pkg::BYTE_REG: begin
                        ptr_d = lk_byte_q;
                        tx_d = reg_read(lk_byte_q);
                        ser_out_en_d = rw_q;
                        byte_idx_d = cps_pkg::BYTE_DATA;
                    end
                    default: begin
                        we = !rw_q && (ptr_q <= cps_pkg::REG_ADDR_LAST);
                        wd = lk_byte_q;
                        data_byte_ev = 1'b1;
                        ptr_d = ptr_q + 8'h01;
                        tx_d = reg_read(ptr_q + 8'h01);
                    end
                endcase
            end
        end else if (start_ev) begin
            state_d = cps_pkg::ST_RX;
            bit_cnt_d = 4'h0;
            byte_idx_d = cps_pkg::BYTE_DEV;
            sda_oe_d = 1'b0;
        end else if (stop_ev) begin
            state_d = cps_pkg::ST_IDLE;
            sda_oe_d = 1'b0;
        end else begin
            case (state_q)
                cps_pkg::ST_IDLE: begin
                    sda_oe_d = 1'b0;
                end
                cps_pkg::ST_RX: begin
                    if (scl_rise && bit_cnt_q != cps_pkg::BITS_PER_BYTE) begin
                        shift_d = {shift_q[6:0], sda_sync_q[1]};
                        bit_cnt_d = bit_cnt_q + 4'h1;
                    end else if (scl_fall && bit_cnt_q == cps_pkg::BITS_PER_BYTE) begin
                        bit_cnt_d = 4'h0;
                        state_d = cps_pkg::ST_ACK;
                        sda_oe_d = 1'b1;
                        case (byte_idx_q)
                            cps_pkg::BYTE_DEV: begin
                                rw_d = shift_q[0];
                                if (shift_q[7:1] != dev_addr) begin
                                    state_d = cps_pkg::ST_IDLE;
                                    sda_oe_d = 1'b0;
                                end
                            end
                            cps_pkg::BYTE_REG: begin
                                ptr_d = shift_q;
                            end
                            default: begin
                                we = (ptr_q <= cps_pkg::REG_ADDR_LAST);
                                data_byte_ev = 1'b1;
                                ptr_d = ptr_q + 8'h01;
                            end
                        endcase
                    end
                end
                cps_pkg::ST_ACK: begin
                    if (scl_fall) begin
                        if (rw_q) begin
                            state_d = cps_pkg::ST_TX;
                            tx_d = rd_now;
                            sda_oe_d = !rd_now[7];
                            bit_cnt_d = 4'h1;
                            byte_idx_d = cps_pkg::BYTE_DATA;
                        end else begin
                            state_d = cps_pkg::ST_RX;
                            sda_oe_d = 1'b0;
                            byte_idx_d = (byte_idx_q == cps_pkg::BYTE_DEV) ? cps_pkg::BYTE_REG : cps_pkg::BYTE_DATA;
                        end
                    end
                end
                cps_pkg::ST_TX: begin
                    if (scl_fall) begin
                        if (bit_cnt_q == cps_pkg::BITS_PER_BYTE) begin
                            state_d = cps_pkg::ST_MACK;
                            sda_oe_d = 1'b0;
                            data_byte_ev = 1'b1;
                            ptr_d = ptr_q + 8'h01;
                        end else begin
                            tx_d = {tx_q[6:0], 1'b0};
                            sda_oe_d = !tx_q[6];
                            bit_cnt_d = bit_cnt_q + 4'h1;
                        end
                    end
                end
                cps_pkg::ST_MACK: begin
                    if (scl_rise) begin
                        acked_d = !sda_sync_q[1];
                    end else if (scl_fall) begin
                        if (acked_q) begin
                            state_d = cps_pkg::ST_TX;
                            tx_d = rd_now;
                            sda_oe_d = !rd_now[7];
                            bit_cnt_d = 4'h1;
                        end else begin
                            state_d = cps_pkg::ST_IDLE;
                        end
                    end
                end
                default: begin
                    state_d = cps_pkg::ST_IDLE;
                    sda_oe_d = 1'b0;
                end
            endcase
        end
        regs_d = regs_q;
        if (we) begin
            regs_d[5'(wa - cps_pkg::REG_ADDR_FIRST)] = wd;
        end
    end

    // runs on the core clock only, independent of the audio master clock
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= cps_pkg::ST_IDLE;
            bit_cnt_q <= 4'h0;
            shift_q <= 8'h00;
            ptr_q <= 8'h00;
            byte_idx_q <= cps_pkg::BYTE_DEV;
            entry_cnt_q <= 2'h0;
            rw_q <= 1'b0;
            sda_oe_q <= 1'b0;
            acked_q <= 1'b0;
            spi_live_q <= 1'b0;
            ser_out_en_q <= 1'b0;
            tx_q <= 8'h00;
            wr_stb_q <= 1'b0;
            wr_addr_q <= 8'h00;
            wr_data_q <= 8'h00;
            for (int i = 0; i < cps_pkg::REG_COUNT; i++) begin
                regs_q[i] <= cps_pkg::REG_RESET_VALUE;
            end
        end else begin
            state_q <= state_d;
            bit_cnt_q <= bit_cnt_d;
            shift_q <= shift_d;
            ptr_q <= ptr_d;
            byte_idx_q <= byte_idx_d;
            entry_cnt_q <= entry_cnt_d;
            rw_q <= rw_d;
            sda_oe_q <= sda_oe_d;
            acked_q <= acked_d;
            spi_live_q <= spi_live_d;
            ser_out_en_q <= ser_out_en_d;
            tx_q <= tx_d;
            wr_stb_q <= we;
            wr_addr_q <= wa;
            wr_data_q <= wd;
            regs_q <= regs_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // no clock output; in i2c mode the data pin is only pulled low
    assign sda_out = spi_mode && ser_out_q;
    assign sda_oe = spi_mode ? ser_out_en_q : sda_oe_q;
    assign reg_wr_stb = wr_stb_q;
    assign reg_wr_addr = wr_addr_q;
    assign reg_wr_data = wr_data_q;

    always_comb begin
        for (int i = 0; i < cps_pkg::REG_COUNT; i++) begin
            reg_image[8*i +: 8] = regs_q[i];
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence dev_byte_done;
        state_q == cps_pkg::ST_RX && byte_idx_q == cps_pkg::BYTE_DEV && bit_cnt_q == cps_pkg::BITS_PER_BYTE
            && scl_fall && !start_ev && !stop_ev && !spi_mode;
    endsequence
    sequence third_latch_fall;
        latch_fall && entry_cnt_q == 2'h2;
    endsequence

    AST_START_RX: assert property (start_ev |=> state_q == cps_pkg::ST_RX && bit_cnt_q == 4'h0)
        else $error("start did not begin address reception");
    AST_STOP_IDLE: assert property (stop_ev |=> state_q == cps_pkg::ST_IDLE && !sda_oe)
        else $error("stop did not return to idle");
    AST_ADDR_ACK: assert property (dev_byte_done ##0 (shift_q[7:1] == dev_addr) |=> state_q == cps_pkg::ST_ACK && sda_oe)
        else $error("matching address not acknowledged");
    AST_MISMATCH: assert property (dev_byte_done ##0 (shift_q[7:1] != dev_addr) |=> state_q == cps_pkg::ST_IDLE && !sda_oe)
        else $error("mismatched address not released");
    AST_ACK_LOW: assert property (state_q == cps_pkg::ST_ACK |-> sda_oe && !sda_out)
        else $error("ack phase does not pull data low");
    AST_OPEN_DRAIN: assert property (!spi_mode |-> !sda_out)
        else $error("data driven high in i2c mode");
    AST_TX_BIT: assert property (state_q == cps_pkg::ST_TX && !spi_mode |-> sda_oe == !tx_q[7])
        else $error("read data bit wrong on the line");
    AST_SDA_SCL_LOW: assert property ((!spi_mode && $changed(sda_oe) && !$past(start_ev) && !$past(stop_ev)
        && !$past(spi_mode)) |-> !$past(scl_sync_q[1]))
        else $error("data changed while clock high");
    AST_NACK_IDLE: assert property ((state_q == cps_pkg::ST_MACK && scl_fall && !acked_q && !start_ev && !stop_ev
        && !spi_mode) |=> state_q == cps_pkg::ST_IDLE)
        else $error("no master ack but read continued");
    AST_PTR_INC: assert property (data_byte_ev |=> ptr_q == $past(ptr_q) + 8'h01)
        else $error("register address did not advance");
    AST_SPI_ENTRY: assert property (third_latch_fall |=> spi_mode ##1 spi_mode)
        else $error("third latch low did not enter spi mode");
    AST_WR_RANGE: assert property (reg_wr_stb |-> reg_wr_addr <= cps_pkg::REG_ADDR_LAST && $past(we))
        else $error("write outside the register space");
endmodule // cps_control_port

// ===== cps_master_model.sv
/*
 * Behavioural control-port master: bit-banged i2c transfers and spi frames.
 * Assumes the bench resolves the data line with a pull-up and open drain.
 */
`timescale 1ns/100ps
module cps_master_model (
    // pacing clock
    input wire logic core_clk,
    // pins toward the port
    output logic scl,
    output logic sda_low,
    output logic pin_lo,
    output logic pin_hi,
    input wire logic sda_line
);
    // ----------------------------------------
    // i2c
    // ----------------------------------------
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
        pin_lo = 1'b0;
        pin_hi = 1'b0;
    end
    task automatic half();
        repeat (6) @(negedge core_clk);
    endtask
    task automatic start();
        sda_low = 1'b0;
        half();
        scl = 1'b1;
        half();
        sda_low = 1'b1;
        half();
        scl = 1'b0;
    endtask
    task automatic stop();
        sda_low = 1'b1;
        half();
        scl = 1'b1;
        half();
        sda_low = 1'b0;
        half();
    endtask
    task automatic send(input logic [7:0] b, input int n, output logic ack);
        for (int i = 7; i > 7 - n; i--) begin
            sda_low = ~b[i];
            half();
            scl = 1'b1;
            half();
            scl = 1'b0;
        end
        ack = 1'b0;
        if (n == 8) begin
            sda_low = 1'b0;
            half();
            scl = 1'b1;
            ack = (sda_line === 1'b0);
            half();
            scl = 1'b0;
        end
    endtask
    task automatic recv(output logic [7:0] b, input logic mack);
        sda_low = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            half();
            scl = 1'b1;
            b[i] = sda_line;
            half();
            scl = 1'b0;
        end
        sda_low = mack;
        half();
        scl = 1'b1;
        half();
        scl = 1'b0;
    endtask
    // ----------------------------------------
    // spi: 32 ns clock only inside frames, pause after each byte
    // ----------------------------------------
    task automatic spi_frame(input logic [23:0] tx, output logic [7:0] rx);
        @(negedge core_clk);
        scl = 1'b0;
        #3 pin_lo = 1'b0;
        #20;
        for (int i = 23; i >= 0; i--) begin
            pin_hi = tx[i];
            #16 scl = 1'b1;
            if (i < 8) rx[i] = sda_line;
            #(i % 8 == 0 ? 80 : 16);
            scl = 1'b0;
        end
        #20 pin_lo = 1'b1;
        #200;
    endtask
endmodule // cps_master_model

// ===== tb_top.sv
/*
 * Self-checking bench of the control port: i2c writes, reads, aborts,
 * then spi entry with one spi write and read.
 * Assumes cps_pkg, the design and the master model compile first.
 */
`timescale 1ns/100ps
module tb_top;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic core_clk, rst_n, scl, sda_low, pin_lo, pin_hi, sda_line;
    logic sda_out, sda_oe, spi_mode, reg_wr_stb;
    logic [7:0] reg_wr_addr, reg_wr_data;
    logic [8*cps_pkg::REG_COUNT-1:0] reg_image;
    logic [7:0] exp_regs [cps_pkg::REG_COUNT];
    int miscompares;
    int check_count;
    int cycles;
    int wr_count;
    logic [7:0] last_wr_addr, last_wr_data;
    assign sda_line = ~(sda_low | (sda_oe & ~sda_out));
    cps_control_port u_cps_control_port (.core_clk(core_clk), .rst_n(rst_n), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe), .scl_spi_serial_clock(scl),
        .addr_strap_lo_spi_chip_select_latch_n(pin_lo), .addr_strap_hi_spi_serial_in(pin_hi),
        .spi_mode(spi_mode), .reg_wr_stb(reg_wr_stb), .reg_wr_addr(reg_wr_addr),
        .reg_wr_data(reg_wr_data), .reg_image(reg_image));
    cps_master_model u_cps_master_model (.core_clk(core_clk), .scl(scl), .sda_low(sda_low),
        .pin_lo(pin_lo), .pin_hi(pin_hi), .sda_line(sda_line));
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    // records every register write strobe seen at the port
    always @(negedge core_clk) begin
        if (reg_wr_stb === 1'b1) begin
            wr_count <= wr_count + 1;
            last_wr_addr <= reg_wr_addr;
            last_wr_data <= reg_wr_data;
        end
    end
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            miscompares++;
            report_and_stop();
        end
    end
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic check_image();
        for (int n = 0; n < cps_pkg::REG_COUNT; n++) check(reg_image[8*n +: 8], exp_regs[n], "register");
    endtask
    function automatic logic [7:0] dev(input logic hi, input logic lo, input logic rd);
        return {hi, lo, cps_pkg::DEV_ADDR_LOW, rd};
    endfunction
    task automatic wr(input logic [7:0] d, input logic [7:0] ra, input logic [7:0] dat[$], input logic ok);
        logic ack;
        u_cps_master_model.start();
        u_cps_master_model.send(d, 8, ack);
        check({7'h0, ack}, {7'h0, ok}, "address ack");
        if (ack) begin
            u_cps_master_model.send(ra, 8, ack);
            check({7'h0, ack}, 8'h01, "index ack");
            foreach (dat[i]) begin
                u_cps_master_model.send(dat[i], 8, ack);
                check({7'h0, ack}, 8'h01, "data ack");
            end
        end
        u_cps_master_model.stop();
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_addr();
        for (int k = 0; k < 4; k++) begin
            @(negedge core_clk);
            pin_hi_lo(k[0], k[1]);
            wr(dev(~k[0], k[1], 1'b0), 8'h09, {8'hee}, 1'b0);
            wr(dev(k[0], k[1], 1'b0), 8'(k + 1), {8'ha0 + 8'(k)}, 1'b1);
            exp_regs[k + 1] = 8'ha0 + 8'(k);
        end
        check_image();
        $display("test addr done");
    endtask
    task automatic pin_hi_lo(input logic hi, input logic lo);
        u_cps_master_model.pin_hi = hi;
        u_cps_master_model.pin_lo = lo;
        repeat (4) @(negedge core_clk);
    endtask
    task automatic t_burst();
        int n0;
        n0 = wr_count;
        wr(dev(1'b1, 1'b1, 1'b0), 8'h19, {8'h11, 8'h22, 8'h33}, 1'b1);
        exp_regs[25] = 8'h11;
        exp_regs[26] = 8'h22;
        check_image();
        check(8'(wr_count - n0), 8'h02, "write strobes");
        check(last_wr_addr, 8'h1a, "write address");
        check(last_wr_data, 8'h22, "write data");
        $display("test burst done");
    endtask
    task automatic t_read();
        logic ack;
        logic [7:0] b;
        u_cps_master_model.start();
        u_cps_master_model.send(dev(1'b1, 1'b1, 1'b0), 8, ack);
        u_cps_master_model.send(8'h19, 8, ack);
        u_cps_master_model.start();
        u_cps_master_model.send(dev(1'b1, 1'b1, 1'b1), 8, ack);
        check({7'h0, ack}, 8'h01, "read ack");
        u_cps_master_model.recv(b, 1'b1);
        check(b, 8'h11, "read 0x19");
        u_cps_master_model.recv(b, 1'b1);
        check(b, 8'h22, "read 0x1a");
        u_cps_master_model.recv(b, 1'b0);
        check(b, 8'h00, "read 0x1b");
        u_cps_master_model.stop();
        $display("test read done");
    endtask
    task automatic t_abort();
        logic ack;
        u_cps_master_model.start();
        u_cps_master_model.send(dev(1'b1, 1'b1, 1'b0), 8, ack);
        u_cps_master_model.send(8'h07, 8, ack);
        u_cps_master_model.send(8'hff, 4, ack);
        u_cps_master_model.stop();
        check({7'h0, sda_oe}, 8'h00, "bus released");
        wr(dev(1'b1, 1'b1, 1'b0), 8'h08, {8'h3c}, 1'b1);
        exp_regs[8] = 8'h3c;
        check_image();
        $display("test abort done");
    endtask
    task automatic t_spi();
        logic [7:0] rx;
        check({7'h0, spi_mode}, 8'h00, "i2c mode");
        repeat (3) u_cps_master_model.spi_frame(24'h000000, rx);
        check({7'h0, spi_mode}, 8'h01, "spi mode");
        u_cps_master_model.spi_frame(24'h00027e, rx);
        exp_regs[2] = 8'h7e;
        check_image();
        check(last_wr_addr, 8'h02, "spi write address");
        check(last_wr_data, 8'h7e, "spi write data");
        u_cps_master_model.spi_frame(24'h010200, rx);
        check(rx, 8'h7e, "spi read");
        $display("test spi done");
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        rst_n = 1'b0;
        for (int n = 0; n < cps_pkg::REG_COUNT; n++) exp_regs[n] = cps_pkg::REG_RESET_VALUE;
        repeat (10) @(negedge core_clk);
        rst_n = 1'b1;
        repeat (4) @(negedge core_clk);
        check_image();
        t_addr();
        t_burst();
        t_read();
        t_abort();
        t_spi();
        report_and_stop();
    end
endmodule // tb_top
